// [deep_sleep_clock_gate_regs.vh]
`ifndef DEEP_SLEEP_CLOCK_GATE_REGS_VH
`define DEEP_SLEEP_CLOCK_GATE_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SYSCTL_BASE_ADDR 32'h400fe000
`define DEEP_GATE_OFFSET 12'h128
`define DEEP_GATE_RESET 32'h00000000
`define DEEP_GATE_WRITE_MASK 32'h5000007f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PHY_CLOCK_ENABLE_BIT 30
`define MAC_CLOCK_ENABLE_BIT 28
`define PORT_A_CLOCK_ENABLE_BIT 0
`define PORT_G_CLOCK_ENABLE_BIT 6

// ----------------------------------------------------------------
// Unit indices on the enable vector
// ----------------------------------------------------------------
`define UNIT_COUNT 9
`define UNIT_MAC_INDEX 7
`define UNIT_PHY_INDEX 8

`endif

// [unit_clock_stage.v]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// One unit: registered clock enable and access fault
// ----------------------------------------------------------------
module unit_clock_stage (
  input wire clk,          // System clock
  input wire rst,          // Asynchronous reset, active high
  input wire enable_next,  // Enable chosen for the active power mode
  input wire access,       // Bus access aimed at this unit
  output reg clk_en,       // Clock enable for the unit's gate cell
  output reg fault         // Bus fault, high the cycle after each access made while clk_en is low
);

  // Enable changes only on a clock edge or when rst rises, so a latch-based gate cell
  // downstream sees a mid-cycle edge only at reset and cuts no pulse
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_en <= 1'b0;
      fault <= 1'b0;
    end else begin
      clk_en <= enable_next;
      fault <= access & ~clk_en;
    end
  end

endmodule // unit_clock_stage

`default_nettype wire

// [deep_sleep_clock_gate.v]
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_clock_gate_regs.vh"

module deep_sleep_clock_gate #(
  parameter ADDR_WIDTH = 12,  // Register port address width
  parameter UNITS = 9         // Number of gated units
) (
  input wire clk,                     // System clock, 125 MHz
  input wire rst,                     // Asynchronous reset, active high
  input wire [ADDR_WIDTH-1:0] addr,   // Register byte offset
  input wire [31:0] wdata,            // Write data
  input wire wr,                      // Write strobe
  input wire rd,                      // Read strobe
  output reg [31:0] rdata,            // Read data, cycle after rd
  input wire sleep,                   // System is in sleep
  input wire deep_sleep,              // System is in deep sleep
  input wire auto_clock_gating,       // Auto gating bit of run_clock_config
  input wire [31:0] run_clock_gate_2,    // Run-mode gating register value
  input wire [31:0] sleep_clock_gate_2,  // Sleep-mode gating register value
  input wire [UNITS-1:0] unit_access,    // Bus access aimed at each unit
  output wire [UNITS-1:0] unit_clk_en,   // Registered clock enable per unit
  output wire [UNITS-1:0] unit_fault     // Registered bus fault pulse per unit
);

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  localparam [1:0] MODE_RUN = 2'b00;
  localparam [1:0] MODE_SLEEP = 2'b01;
  localparam [1:0] MODE_DEEP = 2'b10;

  // ----------------------------------------------------------------
  // Field extraction, used for all three gating registers
  // ----------------------------------------------------------------
  function [8:0] unit_enables;
    input [31:0] word;
    begin
      unit_enables = {word[`PHY_CLOCK_ENABLE_BIT],
                      word[`MAC_CLOCK_ENABLE_BIT],
                      word[`PORT_G_CLOCK_ENABLE_BIT:`PORT_A_CLOCK_ENABLE_BIT]};
    end
  endfunction

  reg [31:0] deep_sleep_clock_gate_2_reg;
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg [8:0] enable_next;
  wire hit;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  assign hit = (addr == `DEEP_GATE_OFFSET);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      deep_sleep_clock_gate_2_reg <= `DEEP_GATE_RESET;
      rdata <= 32'h00000000;
    end else begin
      if (wr && hit) begin
        // Reserved bits stay zero whatever is written
        deep_sleep_clock_gate_2_reg <= wdata & `DEEP_GATE_WRITE_MASK;
      end
      if (rd && hit) begin
        rdata <= deep_sleep_clock_gate_2_reg;
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  always @* begin
    mode_next = MODE_RUN;
    if (auto_clock_gating && deep_sleep) begin
      mode_next = MODE_DEEP;
    end else if (auto_clock_gating && sleep) begin
      mode_next = MODE_SLEEP;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  always @* begin
    case (mode_reg)
      MODE_DEEP: enable_next = unit_enables(deep_sleep_clock_gate_2_reg);
      MODE_SLEEP: enable_next = unit_enables(sleep_clock_gate_2);
      MODE_RUN: enable_next = unit_enables(run_clock_gate_2);
      default: enable_next = 9'h000;
    endcase
  end

  // ----------------------------------------------------------------
  // Per-unit enable and fault
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < UNITS; i = i + 1) begin : g_unit
      unit_clock_stage u_stage (
        .clk(clk),
        .rst(rst),
        .enable_next(enable_next[i]),
        .access(unit_access[i]),
        .clk_en(unit_clk_en[i]),
        .fault(unit_fault[i])
      );
    end
  endgenerate

endmodule // deep_sleep_clock_gate

`default_nettype wire

// [deep_sleep_clock_gate_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_clock_gate_regs.vh"
module deep_sleep_clock_gate_sva #(
  parameter ADDR_WIDTH = 12,
  parameter UNITS = 9
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [ADDR_WIDTH-1:0] addr, // offset
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [31:0] rdata, // read data
  input wire logic sleep, // sleep
  input wire logic deep_sleep, // deep sleep
  input wire logic auto_clock_gating, // auto gating
  input wire logic [31:0] run_clock_gate_2, // run gating
  input wire logic [31:0] sleep_clock_gate_2, // sleep gating
  input wire logic [UNITS-1:0] unit_access, // accesses
  input wire logic [UNITS-1:0] unit_clk_en, // enables
  input wire logic [UNITS-1:0] unit_fault // faults
);
  logic [31:0] shadow_reg;
  always_ff @(posedge clk or posedge rst)
    if (rst) shadow_reg <= '0;
    else if (wr && addr == 'h128) shadow_reg <= wdata & `DEEP_GATE_WRITE_MASK;
  function automatic logic [8:0] pick(logic [31:0] w);
    return {w[30], w[28], w[6:0]};
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence deep_held;
    (auto_clock_gating && deep_sleep && $stable(shadow_reg)) [*3];
  endsequence
  sequence sleep_held;
    (auto_clock_gating && sleep && !deep_sleep && $stable(sleep_clock_gate_2)) [*3];
  endsequence
  sequence run_held;
    (!auto_clock_gating && $stable(run_clock_gate_2)) [*3];
  endsequence
  deep_gate_a: assert property (deep_held |-> unit_clk_en == pick(shadow_reg))
    else $error("deep gating mismatch");
  sleep_gate_a: assert property (sleep_held |-> unit_clk_en == pick(sleep_clock_gate_2))
    else $error("sleep gating mismatch");
  run_gate_a: assert property (run_held |-> unit_clk_en == pick(run_clock_gate_2))
    else $error("run gating mismatch");
  rd_answer_a: assert property (rd && addr == 'h128 |=> rdata == $past(shadow_reg))
    else $error("read data mismatch");
  rd_unmapped_a: assert property (rd && addr != 'h128 |=> rdata == 0)
    else $error("unmapped read not zero");
  rd_idle_a: assert property (!rd |=> rdata == 0)
    else $error("read data outside answer");
  reset_clear_a: assert property ($fell(rst) |-> unit_clk_en == 0 && rdata == 0)
    else $error("not clear after reset");
  access_fault_a: assert property (1 |=> unit_fault == $past(unit_access & ~unit_clk_en))
    else $error("fault mismatch");
endmodule // deep_sleep_clock_gate_sva
bind deep_sleep_clock_gate deep_sleep_clock_gate_sva #(.ADDR_WIDTH(ADDR_WIDTH), .UNITS(UNITS))
  deep_sleep_clock_gate_sva_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .sleep, .deep_sleep,
  .auto_clock_gating, .run_clock_gate_2, .sleep_clock_gate_2, .unit_access, .unit_clk_en,
  .unit_fault);
`default_nettype wire

// [deep_sleep_clock_gate_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_clock_gate_regs.vh"
module deep_sleep_clock_gate_tb;
  logic clk, rst, wr, rd, sleep, deep_sleep, auto_clock_gating;
  logic [11:0] addr, ad;
  logic [31:0] wdata, rdata, run_clock_gate_2, sleep_clock_gate_2, m, r, s;
  logic [8:0] unit_access, unit_clk_en, unit_fault, a;
  int errors = 0, n_compared = 0;
  deep_sleep_clock_gate deep_sleep_clock_gate_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .sleep, .deep_sleep, .auto_clock_gating, .run_clock_gate_2, .sleep_clock_gate_2,
    .unit_access, .unit_clk_en, .unit_fault);
  function automatic logic [8:0] pick(logic [31:0] w);
    return {w[30], w[28], w[6:0]};
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(bit w, logic [11:0] ad_i, logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= ad_i;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  task automatic conclude;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #50000;
    errors++;
    conclude();
  end
  initial begin
    {rst, wr, rd, sleep, deep_sleep, auto_clock_gating} = 6'h20;
    {addr, wdata, run_clock_gate_2, sleep_clock_gate_2, unit_access} = '0;
    m = 0;
    void'($urandom(90544));
    repeat (4) @(posedge clk);
    rst <= 0;
    bus(0, 12'h128, 0);
    check(rdata, 0);
    for (int i = 0; i < 40; i++) begin
      ad = (i % 3 == 0) ? 12'h12c : 12'h128;
      r = $urandom;
      bus(1, ad, r);
      if (ad == 12'h128) m = r & `DEEP_GATE_WRITE_MASK;
      bus(0, 12'h128, 0);
      check(rdata, m);
      bus(0, 12'h12c, 0);
      check(rdata, 0);
      @(posedge clk);
      auto_clock_gating <= i % 4 == 1 || i % 4 == 2;
      // Deep sleep with sleep also high must still pick the deep register
      sleep <= i[0] || i % 8 == 6;
      deep_sleep <= i[1];
      run_clock_gate_2 <= $urandom;
      sleep_clock_gate_2 <= $urandom;
      repeat (3) @(posedge clk);
      #1;
      s = i % 4 == 1 ? sleep_clock_gate_2 : i % 4 == 2 ? m : run_clock_gate_2;
      check(unit_clk_en, pick(s));
      a = $urandom;
      @(posedge clk);
      unit_access <= a;
      @(posedge clk);
      unit_access <= 0;
      #1;
      check(unit_fault, a & ~unit_clk_en);
    end
    // Mid-run reset must clear the register and every enable
    bus(1, 12'h128, 32'h5000007f);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    #1;
    check(unit_clk_en, 0);
    bus(0, 12'h128, 0);
    check(rdata, 0);
    conclude();
  end
endmodule // deep_sleep_clock_gate_tb
`default_nettype wire
